// ===== src/flash_regs_map.vh
// command codes, register field positions, defaults and timing of the flash register bank
`ifndef FLASH_REGS_MAP_VH
`define FLASH_REGS_MAP_VH
`define CMD_WREN     8'h06
`define CMD_WRDI     8'h04
`define CMD_RDSR_LO  8'h05
`define CMD_RDSR_HI  8'h35
`define CMD_READ_CONFIG_CMD     8'h15
`define CMD_WRSR_LO  8'h01
`define CMD_WRSR_HI  8'h31
`define CMD_WRCR     8'h11
`define CMD_SUSPEND  8'h75
`define CMD_RESUME   8'h7A
`define CMD_PP       8'h02
`define CMD_PE       8'h81
`define CMD_SE       8'h20
`define CMD_BE       8'hD8
`define CMD_CE       8'h60
`define CMD_CE2      8'hC7
`define ST_WIP       0
`define ST_WEL       1
`define ST_BP_LSB    2
`define ST_STATUS_LOCK_LO      7
`define ST_STATUS_LOCK_HI      8
`define ST_QE        9
`define ST_FAIL      10
`define ST_LB_LSB    11
`define ST_CMP       14
`define ST_SUS       15
`define CF_DLP       0
`define CF_DC        1
`define CF_WPS       2
`define CF_MPM_LSB   3
`define CF_DRV_LSB   5
`define CF_PFS       7
`define QE_DEFAULT   1'b1
`define CFG_DEFAULT  8'h00
`define PCT_60       8'h3C
`define PCT_100      8'h64
`define PCT_140      8'h8C
`define PCT_40       8'h28
`define PAGE_256     11'h100
`define PAGE_512     11'h200
`define PAGE_1024    11'h400
`define DUMMY_2IO_0  4'h4
`define DUMMY_2IO_1  4'h8
`define DUMMY_4IO_0  4'h6
`define DUMMY_4IO_1  4'hA
`define CLK_MHZ      20
`define TW_US        2000
`define PP_US        500
`define PE_US        2000
`define SE_US        4000
`define BE_US        8000
`define CE_US        16000
`endif

// ===== src/flash_status_config_regs.v
// status and configuration register bank of a serial flash, serial command port
`timescale 1ns/100ps
`include "flash_regs_map.vh"
module flash_status_config_regs #(
    parameter BLK_W  = 6,
    parameter TW_CYC = `TW_US * `CLK_MHZ,
    parameter PP_CYC = `PP_US * `CLK_MHZ,
    parameter PE_CYC = `PE_US * `CLK_MHZ,
    parameter SE_CYC = `SE_US * `CLK_MHZ,
    parameter BE_CYC = `BE_US * `CLK_MHZ,
    parameter CE_CYC = `CE_US * `CLK_MHZ
)(
    // clock and power-up reset
    input  wire        core_clk,
    input  wire        rst,
    // serial link
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        si,
    output reg         so,
    output wire        so_oe,
    // shared pins
    input  wire        io2_in,
    input  wire        io3_in,
    output wire        quad_io_en,
    output wire        pause_fn_en,
    output wire        reset_fn_en,
    // stored non-volatile copies
    input  wire [15:0] nv_status_in,
    input  wire [7:0]  nv_config_in,
    output wire [15:0] nv_status_out,
    output wire [7:0]  nv_config_out,
    output reg         nv_store,
    // array datapath
    output reg         array_start,
    output reg  [2:0]  array_kind,
    output reg  [23:0] array_addr,
    input  wire        array_fail,
    output wire        array_paused,
    // configuration and status outputs
    output wire [10:0] page_bytes,
    output wire [2:0]  erase_pages,
    output wire [3:0]  dummy_2io,
    output wire [3:0]  dummy_4io,
    output wire [1:0]  drive_strength,
    output wire [7:0]  drive_pct,
    output wire        learning_pattern_en,
    output wire [2:0]  security_lock_bits,
    output wire        write_in_progress
);

localparam ST_IDLE  = 2'd0;
localparam ST_REG   = 2'd1;
localparam ST_ARRAY = 2'd2;
localparam BLOCKS   = 1 << BLK_W;

////////////////////////////////////////////////////////////////
reg [2:0]         sclk_q;
reg [2:0]         cs_q;
reg [1:0]         si_q;
reg [1:0]         io2_q;
reg [1:0]         io3_q;
reg [13:0]        bit_cnt_r;
reg [15:0]        sr_r;
reg [7:0]         cmd_r;
reg [23:0]        addr_r;
reg               rd_mode_r;
reg [1:0]         rd_sel_r;
reg [2:0]         ob_r;
reg [7:0]         out_sr_r;
reg [1:0]         st_r;
reg [31:0]        cnt_r;
reg               load_r;
reg               wel_r;
reg [4:0]         bp_r;
reg               status_lock_lo_r;
reg               status_lock_hi_r;
reg               qe_r;
reg               fail_r;
reg [2:0]         lb_r;
reg               cmp_r;
reg               sus_r;
reg               pfs_r;
reg [1:0]         drv_r;
reg [1:0]         mpm_r;
reg               wps_r;
reg               dc_r;
reg               dlp_r;
reg [BLOCKS-1:0]  blk_lock_r;

// protected-region test from protect bits and invert bit
function prot_hit;
    input [BLK_W-1:0] blk;
    input [4:0]       bp;
    input             cmp;
    reg               top;
    begin
        top = 1'b0;
        if (bp >= 5'h07)
            top = 1'b1;
        else if (bp != 5'h00)
            top = ({1'b0, blk} >= (7'h40 - (7'h01 << (bp - 5'h01))));
        prot_hit = top ^ cmp;
    end
endfunction

////////////////////////////////////////////////////////////////
wire        wp_lvl   = qe_r | io2_q[1];
wire        hold_act = ~qe_r & ~pfs_r & ~io3_q[1];
wire        rst_pin  = ~qe_r & pfs_r & ~io3_q[1];
wire        busy     = (st_r != ST_IDLE);
wire        sck_rise = ~cs_q[1] & ~hold_act & ~load_r & (sclk_q[2:1] == 2'b01);
wire        sck_fall = ~cs_q[1] & ~hold_act & (sclk_q[2:1] == 2'b10);
wire        cs_rise  = ~load_r & (cs_q[2:1] == 2'b01);
wire        cs_fall  = (cs_q[2:1] == 2'b10);
wire        hw_prot  = ~status_lock_hi_r & status_lock_lo_r & ~wp_lvl;
wire        reg_lock = status_lock_hi_r | hw_prot;
wire        can_wr   = wel_r & ~busy;
wire        can_reg  = can_wr & ~reg_lock;
wire [7:0]  cmd_nxt  = {sr_r[6:0], si_q[1]};
wire        by8      = (bit_cnt_r[2:0] == 3'd0);
wire [BLK_W-1:0] blk = addr_r[16+BLK_W-1:16];
wire        prot     = wps_r ? blk_lock_r[blk] : prot_hit(blk, bp_r, cmp_r);
wire [15:0] stat     = {sus_r, cmp_r, lb_r, fail_r, qe_r, status_lock_hi_r,
                        status_lock_lo_r, bp_r, wel_r, write_in_progress};
wire [7:0]  cfg      = {pfs_r, drv_r, mpm_r, wps_r, dc_r, dlp_r};
wire [7:0]  live     = (rd_sel_r == 2'd0) ? stat[7:0] :
                       (rd_sel_r == 2'd1) ? stat[15:8] : cfg;
wire [7:0]  obyte    = (ob_r == 3'd0) ? live : out_sr_r;

// pin roles and configuration decode
assign write_in_progress   = busy & ~sus_r;
assign quad_io_en          = qe_r;
assign pause_fn_en         = ~qe_r & ~pfs_r;
assign reset_fn_en         = ~qe_r & pfs_r;
assign so_oe               = rd_mode_r & ~cs_q[1];
assign array_paused        = sus_r;
assign nv_status_out       = stat;
assign nv_config_out       = cfg;
assign security_lock_bits  = lb_r;
assign learning_pattern_en = dlp_r;
assign drive_strength      = drv_r;
assign drive_pct = (drv_r == 2'd0) ? `PCT_60 : (drv_r == 2'd1) ? `PCT_100 :
                   (drv_r == 2'd2) ? `PCT_140 : `PCT_40;
assign page_bytes  = (mpm_r == 2'd1) ? `PAGE_512 :
                     (mpm_r == 2'd2) ? `PAGE_1024 : `PAGE_256;
assign erase_pages = (mpm_r == 2'd1) ? 3'd2 : (mpm_r == 2'd2) ? 3'd4 : 3'd1;
assign dummy_2io   = dc_r ? `DUMMY_2IO_1 : `DUMMY_2IO_0;
assign dummy_4io   = dc_r ? `DUMMY_4IO_1 : `DUMMY_4IO_0;

////////////////////////////////////////////////////////////////
// register writes
task wr_lo;
    input [7:0] d;
    begin
        bp_r   <= d[6:2];
        status_lock_lo_r <= d[7];
    end
endtask

task wr_hi;
    input [7:0] d;
    begin
        status_lock_hi_r <= d[0];
        qe_r   <= d[1];
        lb_r   <= lb_r | d[5:3];
        cmp_r  <= d[6];
    end
endtask

task reg_go;
    begin
        st_r     <= ST_REG;
        cnt_r    <= TW_CYC - 1;
        nv_store <= 1'b1;
    end
endtask

// start an array operation unless chk is set and the target is guarded
task arr_go;
    input [2:0]  kind;
    input [31:0] cyc;
    input        chk;
    begin
        if (chk && prot)
        begin
            fail_r <= 1'b1;
            wel_r  <= 1'b0;
        end
        else
        begin
            st_r        <= ST_ARRAY;
            cnt_r       <= cyc - 32'd1;
            array_start <= 1'b1;
            array_kind  <= kind;
            array_addr  <= addr_r;
        end
    end
endtask

////////////////////////////////////////////////////////////////
// pin synchronisers
always @(posedge core_clk)
begin
    if (rst)
    begin
        sclk_q <= 3'b000;
        cs_q   <= 3'b111;
        si_q   <= 2'b00;
        io2_q  <= 2'b11;
        io3_q  <= 2'b11;
    end
    else
    begin
        sclk_q <= {sclk_q[1:0], sclk};
        cs_q   <= {cs_q[1:0], cs_n};
        si_q   <= {si_q[0], si};
        io2_q  <= {io2_q[0], io2_in};
        io3_q  <= {io3_q[0], io3_in};
    end
end

////////////////////////////////////////////////////////////////
always @(posedge core_clk)
begin
    nv_store    <= 1'b0;
    array_start <= 1'b0;
    if (rst)
    begin
        so         <= 1'b0;
        bit_cnt_r  <= 14'd0;
        sr_r       <= 16'h0000;
        cmd_r      <= 8'h00;
        addr_r     <= 24'h000000;
        rd_mode_r  <= 1'b0;
        rd_sel_r   <= 2'd0;
        ob_r       <= 3'd0;
        out_sr_r   <= 8'h00;
        st_r       <= ST_IDLE;
        cnt_r      <= 32'd0;
        load_r     <= 1'b1;
        wel_r      <= 1'b0;
        bp_r       <= 5'h00;
        status_lock_lo_r     <= 1'b0;
        status_lock_hi_r     <= 1'b0;
        qe_r       <= `QE_DEFAULT;
        fail_r     <= 1'b0;
        lb_r       <= 3'h0;
        cmp_r      <= 1'b0;
        sus_r      <= 1'b0;
        {pfs_r, drv_r, mpm_r, wps_r, dc_r, dlp_r} <= `CFG_DEFAULT;
        blk_lock_r <= {BLOCKS{1'b1}};
        array_kind <= 3'd0;
        array_addr <= 24'h000000;
    end
    else if (load_r)
    begin
        load_r <= 1'b0;
        bp_r   <= nv_status_in[`ST_BP_LSB+4:`ST_BP_LSB];
        status_lock_lo_r <= nv_status_in[`ST_STATUS_LOCK_LO];
        status_lock_hi_r <= nv_status_in[`ST_STATUS_LOCK_HI] & nv_status_in[`ST_STATUS_LOCK_LO];
        qe_r   <= nv_status_in[`ST_QE];
        lb_r   <= nv_status_in[`ST_LB_LSB+2:`ST_LB_LSB];
        cmp_r  <= nv_status_in[`ST_CMP];
        pfs_r  <= nv_config_in[`CF_PFS];
        drv_r  <= nv_config_in[`CF_DRV_LSB+1:`CF_DRV_LSB];
        wps_r  <= nv_config_in[`CF_WPS];
    end
    else if (rst_pin)
    begin
        if (st_r == ST_ARRAY)
            fail_r <= 1'b1;
        st_r       <= ST_IDLE;
        wel_r      <= 1'b0;
        sus_r      <= 1'b0;
        rd_mode_r  <= 1'b0;
        bit_cnt_r  <= 14'd0;
        {mpm_r, dc_r, dlp_r} <= 4'h0;
        blk_lock_r <= {BLOCKS{1'b1}};
    end
    else
    begin
        if (busy && !sus_r)
        begin
            if (cnt_r == 32'd0)
            begin
                st_r  <= ST_IDLE;
                wel_r <= 1'b0;
                if (st_r == ST_ARRAY)
                    fail_r <= array_fail;
            end
            else
                cnt_r <= cnt_r - 32'd1;
        end
        if (cs_fall)
        begin
            bit_cnt_r <= 14'd0;
            rd_mode_r <= 1'b0;
        end
        if (sck_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 14'd1;
            sr_r      <= {sr_r[14:0], si_q[1]};
            if (bit_cnt_r == 14'd7)
            begin
                cmd_r <= cmd_nxt;
                ob_r  <= 3'd0;
                if (cmd_nxt == `CMD_RDSR_LO || cmd_nxt == `CMD_RDSR_HI || cmd_nxt == `CMD_READ_CONFIG_CMD)
                    rd_mode_r <= 1'b1;
                rd_sel_r <= (cmd_nxt == `CMD_RDSR_LO) ? 2'd0 :
                            (cmd_nxt == `CMD_RDSR_HI) ? 2'd1 : 2'd2;
            end
            if (bit_cnt_r >= 14'd8 && bit_cnt_r < 14'd32)
                addr_r <= {addr_r[22:0], si_q[1]};
        end
        if (sck_fall && rd_mode_r)
        begin
            so       <= obyte[7];
            out_sr_r <= {obyte[6:0], 1'b0};
            ob_r     <= ob_r + 3'd1;
        end
        if (cs_rise)
        begin
            rd_mode_r <= 1'b0;
            case (cmd_r)
                `CMD_WREN:
                    if (bit_cnt_r == 14'd8 && !busy)
                        wel_r <= 1'b1;
                `CMD_WRDI:
                    if (bit_cnt_r == 14'd8 && !busy)
                        wel_r <= 1'b0;
                `CMD_WRSR_LO:
                    if (can_reg && bit_cnt_r == 14'd16)
                    begin
                        wr_lo(sr_r[7:0]);
                        cmp_r  <= 1'b0;
                        qe_r   <= 1'b0;
                        status_lock_hi_r <= 1'b0;
                        reg_go;
                    end
                    else if (can_reg && bit_cnt_r == 14'd24)
                    begin
                        wr_lo(sr_r[15:8]);
                        wr_hi(sr_r[7:0]);
                        reg_go;
                    end
                `CMD_WRSR_HI:
                    if (can_reg && bit_cnt_r == 14'd16)
                    begin
                        wr_hi(sr_r[7:0]);
                        reg_go;
                    end
                `CMD_WRCR:
                    if (can_reg && bit_cnt_r == 14'd16)
                    begin
                        {pfs_r, drv_r, mpm_r, wps_r, dc_r, dlp_r} <= sr_r[7:0];
                        reg_go;
                    end
                `CMD_SUSPEND:
                    if (bit_cnt_r == 14'd8 && st_r == ST_ARRAY)
                        sus_r <= 1'b1;
                `CMD_RESUME:
                    if (bit_cnt_r == 14'd8)
                        sus_r <= 1'b0;
                `CMD_PP:
                    if (can_wr && bit_cnt_r >= 14'd40 && by8)
                        arr_go(3'd1, PP_CYC, 1'b1);
                `CMD_PE:
                    if (can_wr && bit_cnt_r == 14'd32)
                        arr_go(3'd2, PE_CYC, 1'b1);
                `CMD_SE:
                    if (can_wr && bit_cnt_r == 14'd32)
                        arr_go(3'd3, SE_CYC, 1'b1);
                `CMD_BE:
                    if (can_wr && bit_cnt_r == 14'd32)
                        arr_go(3'd4, BE_CYC, 1'b1);
                `CMD_CE, `CMD_CE2:
                    if (can_wr && bit_cnt_r == 14'd8 && bp_r == 5'h00)
                        arr_go(3'd5, CE_CYC, 1'b0);
                default:
                    ;
            endcase
        end
    end
end

endmodule

// ===== bench/flash_status_config_regs_asserts.sv
// assertion checker for the flash register bank
`timescale 1ns/100ps
`include "flash_regs_map.vh"
module flash_status_config_regs_asserts (
    // clock and reset
    input wire        core_clk,
    input wire        rst,
    // pins and register images
    input wire        cs_n,
    input wire        io2_in,
    input wire        so_oe,
    input wire [15:0] nv_status_out,
    input wire [7:0]  nv_config_out,
    // events and decodes
    input wire        nv_store,
    input wire        array_start,
    input wire [2:0]  array_kind,
    input wire        quad_io_en,
    input wire        pause_fn_en,
    input wire        reset_fn_en,
    input wire [10:0] page_bytes,
    input wire [2:0]  erase_pages,
    input wire [3:0]  dummy_2io,
    input wire [3:0]  dummy_4io,
    input wire [7:0]  drive_pct,
    input wire [2:0]  security_lock_bits,
    input wire        write_in_progress
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire [1:0] mpm = nv_config_out[4:3];
    wire [1:0] drv = nv_config_out[6:5];
    wire       qe  = nv_status_out[`ST_QE];
    wire       pfs = nv_config_out[`CF_PFS];
    sequence s_accept;
        nv_store || array_start;
    endsequence
    sequence s_deselect;
        cs_n [*4];
    endsequence
    a_busy_follows: assert property (s_accept |-> ##[0:4] write_in_progress)
        else $error("busy flag missing after accepted write");
    a_write_needs_wel: assert property (s_accept |-> nv_status_out[`ST_WEL])
        else $error("write taken without enable latch");
    a_lock_refuses: assert property (nv_store |->
        !$past(nv_status_out[`ST_STATUS_LOCK_HI]) && !($past(nv_status_out[`ST_STATUS_LOCK_LO]) && !$past(qe) && !$past(io2_in)))
        else $error("register write taken while locked");
    a_chip_unprot: assert property ((array_start && array_kind == 3'h5) |-> nv_status_out[6:2] == 5'h00)
        else $error("chip erase started while protected");
    a_page_size: assert property (page_bytes == (mpm == 2'h1 ? `PAGE_512 : mpm == 2'h2 ? `PAGE_1024 : `PAGE_256))
        else $error("page size decode wrong");
    a_erase_span: assert property (mpm == 2'h3 || erase_pages == (mpm == 2'h0 ? 3'h1 : mpm == 2'h1 ? 3'h2 : 3'h4))
        else $error("erase span decode wrong");
    a_dummy_count: assert property ({dummy_2io, dummy_4io} ==
        (nv_config_out[`CF_DC] ? {`DUMMY_2IO_1, `DUMMY_4IO_1} : {`DUMMY_2IO_0, `DUMMY_4IO_0}))
        else $error("dummy count decode wrong");
    a_drive_pct: assert property (drive_pct ==
        (drv == 2'h0 ? `PCT_60 : drv == 2'h1 ? `PCT_100 : drv == 2'h2 ? `PCT_140 : `PCT_40))
        else $error("drive strength decode wrong");
    a_pin_roles: assert property (quad_io_en == qe && pause_fn_en == (!qe && !pfs) && reset_fn_en == (!qe && pfs))
        else $error("shared pin role wrong");
    a_lock_sticky: assert property ((!$past(rst) && !$past(rst, 2)) |->
        (security_lock_bits & $past(security_lock_bits)) == $past(security_lock_bits))
        else $error("security lock bit cleared");
    a_deselect_quiet: assert property (s_deselect |-> !so_oe)
        else $error("serial output driven while deselected");
endmodule

bind flash_status_config_regs flash_status_config_regs_asserts flash_status_config_regs_asserts_inst (
    .core_clk, .rst, .cs_n, .io2_in, .so_oe, .nv_status_out, .nv_config_out, .nv_store, .array_start,
    .array_kind, .quad_io_en, .pause_fn_en, .reset_fn_en, .page_bytes, .erase_pages, .dummy_2io,
    .dummy_4io, .drive_pct, .security_lock_bits, .write_in_progress);

// ===== bench/flash_host_model.sv
// host-side serial controller model driving the flash command port
`timescale 1ns/100ps
module flash_host_model (
    // pacing clock
    input  wire core_clk,
    // serial link
    input  wire so,
    output reg  sclk,
    output reg  cs_n,
    output reg  si
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end
    // one frame, msb first, mode 0, 400 ns bit; returns last byte on so
    task automatic xfer(input int n, input logic [39:0] d, output logic [7:0] r);
        int i;
        r = 8'h00;
        cs_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        for (i = n - 1; i >= 0; i--)
        begin
            si <= d[i];
            repeat (4) @(posedge core_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge core_clk);
            r = {r[6:0], so};
            sclk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        cs_n <= 1'b1;
        si   <= ~si;
        repeat (16) @(posedge core_clk);
    endtask
endmodule

// ===== bench/flash_status_config_regs_tb_top.sv
// self-checking bench for the flash register bank
`timescale 1ns/100ps
`include "flash_regs_map.vh"
module flash_status_config_regs_tb_top;
    reg         core_clk;
    reg         rst;
    reg         io2_in;
    reg         io3_in;
    reg  [15:0] nv_status_in;
    reg  [7:0]  nv_config_in;
    reg         array_fail;
    wire        sclk;
    wire        cs_n;
    wire        si;
    wire        so;
    wire [15:0] nv_status_out;
    wire [7:0]  nv_config_out;
    wire        array_start;
    wire [2:0]  array_kind;
    wire        array_paused;
    wire [10:0] page_bytes;
    wire [2:0]  erase_pages;
    wire [3:0]  dummy_2io;
    wire [3:0]  dummy_4io;
    wire [7:0]  drive_pct;
    wire        quad_io_en;
    wire        pause_fn_en;
    wire        reset_fn_en;
    wire        learning_pattern_en;
    wire        write_in_progress;
    wire        so_oe;
    wire        nv_store;
    wire [23:0] array_addr;
    wire [1:0]  drive_strength;
    wire [2:0]  security_lock_bits;
    integer     n_store = 0;
    integer     err_count = 0;
    integer     cmp_count = 0;
    integer     cyc = 0;
    integer     n_start = 0;
    integer     seed;
    integer     i;
    reg  [2:0]  last_kind = 3'h0;
    reg  [15:0] st;
    reg  [7:0]  b;
    reg  [7:0]  c;

    flash_host_model flash_host_model_inst (.core_clk, .so, .sclk, .cs_n, .si);
    flash_status_config_regs #(.TW_CYC(40), .PP_CYC(40), .PE_CYC(40), .SE_CYC(400), .BE_CYC(40), .CE_CYC(40))
    flash_status_config_regs_inst (
        .core_clk, .rst, .sclk, .cs_n, .si, .so, .so_oe, .io2_in, .io3_in, .quad_io_en, .pause_fn_en,
        .reset_fn_en, .nv_status_in, .nv_config_in, .nv_status_out, .nv_config_out, .nv_store, .array_start,
        .array_kind, .array_addr, .array_fail, .array_paused, .page_bytes, .erase_pages, .dummy_2io, .dummy_4io,
        .drive_strength, .drive_pct, .learning_pattern_en, .security_lock_bits, .write_in_progress);

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (nv_store)
            n_store <= n_store + 1;
        if (array_start)
        begin
            n_start   <= n_start + 1;
            last_kind <= array_kind;
        end
        if (cyc == 90000)
        begin
            err_count = err_count + 1;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////
    function [15:0] pg_exp(input [1:0] m);
        pg_exp = m == 2'h1 ? 16'(`PAGE_512) : m == 2'h2 ? 16'(`PAGE_1024) : 16'(`PAGE_256);
    endfunction
    function [15:0] pct_exp(input [1:0] m);
        pct_exp = m == 2'h0 ? 16'(`PCT_60) : m == 2'h1 ? 16'(`PCT_100) : m == 2'h2 ? 16'(`PCT_140) : 16'(`PCT_40);
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cmd(input int n, input logic [39:0] d);
        logic [7:0] r;
        flash_host_model_inst.xfer(n, d, r);
    endtask
    task rd(input logic [7:0] op);
        flash_host_model_inst.xfer(16, {24'h0, op, 8'h00}, b);
    endtask
    // wait out busy by status polling
    task poll;
        int k;
        for (k = 0; k < 40; k++)
        begin
            rd(`CMD_RDSR_LO);
            if (b[0] === 1'b0)
                break;
        end
    endtask
    task wren;
        cmd(8, {32'h0, `CMD_WREN});
    endtask
    task wsr(input logic [7:0] lo, input logic [7:0] hi);
        wren;
        cmd(24, {16'h0, `CMD_WRSR_LO, lo, hi});
        poll;
        st[7:2]   = lo[7:2];
        st[9:8]   = hi[1:0];
        st[14]    = hi[6];
        st[13:11] = st[13:11] | hi[5:3];
    endtask
    task wcr(input logic [7:0] v);
        wren;
        cmd(16, {24'h0, `CMD_WRCR, v});
        repeat (10) @(posedge core_clk);
    endtask
    task wrap_up;
        $display("errors=%0d compares=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h590F;
        rst = 1'b1;
        io2_in = 1'b1;
        io3_in = 1'b1;
        array_fail = 1'b0;
        nv_status_in = 16'h4300;
        nv_config_in = 8'hFB;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (12) @(posedge core_clk);
        st = 16'h4200;
        chk(nv_status_out, st);
        chk(16'(nv_config_out), 16'h00E0);
        rd(`CMD_RDSR_HI);
        chk(16'(b), 16'h0042);
        cmd(24, {16'h0, `CMD_WRSR_LO, 8'h1C, 8'h02});
        repeat (10) @(posedge core_clk);
        chk(nv_status_out, st);
        chk(16'(n_store), 16'h0000);
        wren;
        rd(`CMD_RDSR_LO);
        chk(16'(b), 16'h0002);
        for (i = 0; i < 6; i++)
        begin
            b = $random(seed);
            wsr({1'b0, b[4:0], 2'b00}, {1'b0, b[5], (i == 3) ? 3'b010 : 3'b000, 3'b010});
            chk(nv_status_out, st);
            chk(16'(n_store), 16'(i + 1));
            chk(16'(security_lock_bits), 16'(st[13:11]));
            rd(`CMD_RDSR_HI);
            chk(16'(b), 16'(st[15:8]));
            chk(16'(so_oe), 16'h0000);
        end
        // all blocks guarded: chip erase and program must not start
        wsr(8'h1C, 8'h02);
        wren;
        cmd(8, {32'h0, `CMD_CE});
        wren;
        cmd(40, {`CMD_PP, 24'h000100, 8'hA5});
        repeat (10) @(posedge core_clk);
        st[10] = 1'b1;
        chk(16'(n_start), 16'h0000);
        chk(nv_status_out, st);
        wsr(8'h00, 8'h02);
        wren;
        cmd(32, {8'h0, `CMD_SE, 24'h001000});
        chk(16'(last_kind), 16'h0003);
        chk(array_addr[23:8], 16'h0010);
        chk(16'(write_in_progress), 16'h0001);
        cmd(8, {32'h0, `CMD_SUSPEND});
        chk(16'({array_paused, nv_status_out[15]}), 16'h0003);
        cmd(8, {32'h0, `CMD_RESUME});
        chk(16'(nv_status_out[15]), 16'h0000);
        poll;
        st[10] = 1'b0;
        chk(nv_status_out, st);
        // array reports a failure at the end of the chip erase
        array_fail <= 1'b1;
        wren;
        cmd(8, {32'h0, `CMD_CE});
        chk(16'(last_kind), 16'h0005);
        poll;
        chk(16'(nv_status_out[10]), 16'h0001);
        array_fail <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            c = {1'b0, i[1:0], i[1:0], 1'b0, i[0], i[0]};
            wcr(c);
            poll;
            rd(`CMD_READ_CONFIG_CMD);
            chk(16'(b), 16'(c));
            chk(16'(page_bytes), pg_exp(i[1:0]));
            chk(16'(drive_pct), pct_exp(i[1:0]));
            chk(16'(drive_strength), 16'(i[1:0]));
            chk({dummy_2io, dummy_4io, 7'h0, learning_pattern_en},
                {i[0] ? {`DUMMY_2IO_1, `DUMMY_4IO_1} : {`DUMMY_2IO_0, `DUMMY_4IO_0}, 7'h0, i[0]});
            if (i < 3)
                chk(16'(erase_pages), 16'(1 << i));
        end
        // block locks guard every block from all but chip erase once the scheme bit is set
        c = 8'h04;
        wcr(c);
        poll;
        wren;
        cmd(32, {8'h0, `CMD_SE, 24'h001000});
        repeat (10) @(posedge core_clk);
        chk(16'(n_start), 16'h0002);
        chk(16'(nv_status_out[1]), 16'h0000);
        // write-protect pin takes over once quad mode is off
        wsr(8'h80, 8'h00);
        chk(16'({quad_io_en, pause_fn_en, reset_fn_en}), 16'h0002);
        io2_in <= 1'b0;
        wcr(8'h80);
        chk(16'(nv_config_out), 16'(c));
        io2_in <= 1'b1;
        wcr(8'h80);
        poll;
        chk(16'(nv_config_out), 16'h0080);
        chk(16'({quad_io_en, pause_fn_en, reset_fn_en}), 16'h0001);
        wsr(8'h80, 8'h01);
        wcr(8'h00);
        chk(16'(nv_config_out), 16'h0080);
        wrap_up;
    end
endmodule
